/* include/aancr_consts.svh */
/*
  Constants for the analog network control register bank: register offsets,
  field positions, writable masks and reset values.
  Assumes it is included by its bare name from design files only.
*/
`ifndef AANCR_CONSTS_SVH
`define AANCR_CONSTS_SVH

// Word indices as printed; byte address is four times the index.
`define AANCR_IDX_EXTRA 8'h12
`define AANCR_IDX_FRATE 8'h13
`define AANCR_IDX_CHOP 8'h15
`define AANCR_IDX_INSEL 8'h18
`define AANCR_IDX_REFSEL 8'h19
`define AANCR_IDX_GAIN 8'h1a
`define AANCR_IDX_AMP 8'h1b

// Writable bit masks of each register.
`define AANCR_MASK_FRATE 8'h0f
`define AANCR_MASK_CHOP 8'h0c
`define AANCR_MASK_INSEL 8'hff
`define AANCR_MASK_REFSEL 8'h3f
`define AANCR_MASK_GAIN 8'h8f
`define AANCR_MASK_AMP 8'h0f

// Reset value shared by every register.
`define AANCR_RST_VAL 8'h00

// Field positions.
`define AANCR_COMB_BIT 3
`define AANCR_RATE_LSB 0
`define AANCR_CHOP_LSB 2
`define AANCR_NEG_LSB 6
`define AANCR_FIN_LSB 3
`define AANCR_FEN_BIT 2
`define AANCR_POS_LSB 0
`define AANCR_AINV_LSB 4
`define AANCR_VRL_LSB 2
`define AANCR_VRH_LSB 0
`define AANCR_REFEN_BIT 7
`define AANCR_GAIN_LSB 2
`define AANCR_CEN_BIT 1
`define AANCR_AZ_BIT 0
`define AANCR_AEN_BIT 3
`define AANCR_ANINV_LSB 0

// Output rate divisors per code.
`define AANCR_DIV_125 16'h007d
`define AANCR_DIV_8000 16'h1f40

// AHB transfer type for a nonsequential transfer.
`define AANCR_HTRANS_NONSEQ 2'h2
`define AANCR_HSIZE_WORD 3'h2

`endif

/* include/aancr_pkg.sv */
/*
  Types for the analog network control register bank.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package aancr_pkg;

  // Chopper modes of the amplifier input stage.
  typedef enum logic [1:0] {
    AANCR_CHOP_POS_OFS = 2'b00,
    AANCR_CHOP_NEG_OFS = 2'b01,
    AANCR_CHOP_DIV500 = 2'b10,
    AANCR_CHOP_DIV1000 = 2'b11
  } aancr_chop_t;

  // Bus data phase state of the slave.
  typedef enum logic [0:0] {
    AANCR_ST_IDLE = 1'b0,
    AANCR_ST_WRITE = 1'b1
  } aancr_state_t;

  // Control bundle that steers the analog network.
  typedef struct packed {
    logic comb_filter_enable;
    logic [2:0] output_rate_select;
    logic [1:0] chopper_mode_select;
    logic chop_enable;
    logic chop_polarity_neg;
    logic [1:0] negative_input_select;
    logic [2:0] filter_input_select;
    logic filter_enable;
    logic [1:0] positive_input_select;
    logic [1:0] amp_inverting_select;
    logic [1:0] negative_reference_select;
    logic [1:0] positive_reference_select;
    logic internal_reference_enable;
    logic [1:0] input_gain_select;
    logic converter_enable;
    logic auto_zero_short;
    logic amplifier_enable;
    logic [2:0] amp_noninverting_select;
  } aancr_ctrl_t;

endpackage

/* hdl/aancr_regs.sv */
/*
  Control and status register bank of the sigma-delta converter and the
  low-noise amplifier, reached as an AHB-Lite slave with zero wait states.
  Assumes one clock, synchronous active-low reset, word transfers only,
  and result bytes that come from converter logic on the same clock.
*/
// Chosen here: the AHB-Lite slave port.
// Behaviour
// - Comb filter off forces result to zero.
// - Rate code divides sample frequency, 111=8000.
// - Chop codes 11,10 chop at CLK/1000,/500.
// - Codes 01,00 hold minus/plus offset polarity.
// - Negative input select routes four sources.
// - Filter input select; 011 neg, 010 pos ref.
// - Positive input select, 00 filtered output.
// - Amp inverting select routes four sources.
// - Negative reference select routes four sources.
// - Positive reference select routes four sources.
// - Reference enable drives fifth taps, else floating.
// - Gain code picks 2/3,1,2,7/3.
// - Converter enable bit gates the converter.
// - Auto-zero shorts both inputs to negative source.
// - Amplifier enable bit gates the amplifier.
// - Non-inverting select code n picks channel n.
// - Chopper register only bits 3-2 writable.
// - Filter-enable bit turns low-pass filter on.
// - Filter input codes map eight sources.
`timescale 1ns/1ps
`include "aancr_consts.svh"

module aancr_regs
  import aancr_pkg::*;
#(
  parameter int ADDR_W = 8 // Byte address width kept for writes; reads decode bits 9:2.
)
(
  input wire logic i_sys_clk, // System clock, 100 MHz.
  input wire logic i_nrst, // Synchronous active-low reset.
  input wire logic i_hsel, // Slave select.
  input wire logic [31:0] i_haddr, // Byte address.
  input wire logic [1:0] i_htrans, // Transfer type.
  input wire logic i_hwrite, // High for a write.
  input wire logic [2:0] i_hsize, // Transfer size.
  input wire logic [31:0] i_hwdata, // Write data.
  input wire logic i_hready, // Bus ready from the interconnect.
  input wire logic [23:0] i_conv_result, // Raw converter result, same clock.
  output logic [31:0] o_hrdata, // Read data.
  output logic o_hreadyout, // Slave ready.
  output logic o_hresp, // Response, always OKAY.
  output aancr_ctrl_t o_ctrl, // Registered analog network controls.
  output logic [23:0] o_result, // Result as seen by software.
  output logic [15:0] o_rate_divisor // Sample frequency divisor.
);

  // Stored register contents.
  logic [7:0] frate_reg; // Filter and rate register.
  logic [7:0] chop_reg; // Chopper register.
  logic [7:0] insel_reg; // Input select register.
  logic [7:0] refsel_reg; // Reference select register.
  logic [7:0] gain_reg; // Gain and enable register.
  logic [7:0] amp_reg; // Amplifier select register.

  // Captured address phase.
  aancr_state_t state; // Data phase kind.
  logic [ADDR_W-1:0] wr_addr; // Address of pending write.
  logic [7:0] rd_idx; // Word index of the read request.
  logic addr_ok; // Address phase is a valid word access.
  logic [23:0] next_result; // Result after comb filter gating.
  logic [15:0] next_divisor; // Decoded rate divisor.
  logic [31:0] next_rdata; // Read mux value.
  logic [7:0] wr_idx; // Word index of the pending write.
  logic [7:0] wr_mask; // Writable bits of the pending write target.

  // A transfer is taken when selected, nonsequential and the bus is ready.
  assign addr_ok = i_hsel && i_hready && (i_htrans == `AANCR_HTRANS_NONSEQ);
  assign rd_idx = i_haddr[9:2];
  assign wr_idx = 8'(wr_addr >> 2);

  // Writable bits of the register that the pending write targets. The mask is
  // zero for the read-only byte and for unmapped words, so nothing is forwarded.
  always_comb
  begin
    wr_mask = 8'h00;
    if (wr_idx == `AANCR_IDX_FRATE)
      wr_mask = `AANCR_MASK_FRATE;
    else if (wr_idx == `AANCR_IDX_CHOP)
      wr_mask = `AANCR_MASK_CHOP;
    else if (wr_idx == `AANCR_IDX_INSEL)
      wr_mask = `AANCR_MASK_INSEL;
    else if (wr_idx == `AANCR_IDX_REFSEL)
      wr_mask = `AANCR_MASK_REFSEL;
    else if (wr_idx == `AANCR_IDX_GAIN)
      wr_mask = `AANCR_MASK_GAIN;
    else if (wr_idx == `AANCR_IDX_AMP)
      wr_mask = `AANCR_MASK_AMP;
  end

  // Bus data phase state: a write is completed in its data phase.
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_nrst)
    begin
      state <= AANCR_ST_IDLE;
      wr_addr <= '0;
    end
    else if (addr_ok && i_hwrite)
    begin
      // Remember the write address for the data phase.
      state <= AANCR_ST_WRITE;
      wr_addr <= i_haddr[ADDR_W-1:0];
    end
    else
    begin
      // No write pending.
      state <= AANCR_ST_IDLE;
    end
  end

  // Register writes land on the edge that ends the data phase; unimplemented
  // bits are masked so they keep reading zero.
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_nrst)
    begin
      frate_reg <= `AANCR_RST_VAL;
      chop_reg <= `AANCR_RST_VAL;
      insel_reg <= `AANCR_RST_VAL;
      refsel_reg <= `AANCR_RST_VAL;
      gain_reg <= `AANCR_RST_VAL;
      amp_reg <= `AANCR_RST_VAL;
    end
    else
    begin
      case (state)
        AANCR_ST_WRITE:
        begin
          // Decode the pending write index.
          if (wr_idx == `AANCR_IDX_FRATE)
            frate_reg <= i_hwdata[7:0] & `AANCR_MASK_FRATE;
          else if (wr_idx == `AANCR_IDX_CHOP)
            chop_reg <= i_hwdata[7:0] & `AANCR_MASK_CHOP;
          else if (wr_idx == `AANCR_IDX_INSEL)
            insel_reg <= i_hwdata[7:0] & `AANCR_MASK_INSEL;
          else if (wr_idx == `AANCR_IDX_REFSEL)
            refsel_reg <= i_hwdata[7:0] & `AANCR_MASK_REFSEL;
          else if (wr_idx == `AANCR_IDX_GAIN)
            gain_reg <= i_hwdata[7:0] & `AANCR_MASK_GAIN;
          else if (wr_idx == `AANCR_IDX_AMP)
            amp_reg <= i_hwdata[7:0] & `AANCR_MASK_AMP;
        end
        default:
        begin
          // Nothing to store.
        end
      endcase
    end
  end

  // Result gating and rate decode from the stored fields.
  always_comb
  begin
    // Filter off means the digital result reads as zero.
    if (frate_reg[`AANCR_COMB_BIT])
      next_result = i_conv_result;
    else
      next_result = '0;
    // Codes 000..110 double from 125; 111 stays at 8000.
    if (frate_reg[2:0] == 3'h7)
      next_divisor = `AANCR_DIV_8000;
    else
      next_divisor = 16'(`AANCR_DIV_125 << frate_reg[2:0]);
  end

  // Read mux; unmapped addresses read zero.
  always_comb
  begin
    next_rdata = '0;
    if (rd_idx == `AANCR_IDX_EXTRA)
      next_rdata = {24'h00_0000, next_result[7:0]};
    else if (rd_idx == `AANCR_IDX_FRATE)
      next_rdata = {24'h00_0000, frate_reg};
    else if (rd_idx == `AANCR_IDX_CHOP)
      next_rdata = {24'h00_0000, chop_reg};
    else if (rd_idx == `AANCR_IDX_INSEL)
      next_rdata = {24'h00_0000, insel_reg};
    else if (rd_idx == `AANCR_IDX_REFSEL)
      next_rdata = {24'h00_0000, refsel_reg};
    else if (rd_idx == `AANCR_IDX_GAIN)
      next_rdata = {24'h00_0000, gain_reg};
    else if (rd_idx == `AANCR_IDX_AMP)
      next_rdata = {24'h00_0000, amp_reg};
    // A read taken in the data phase of a write to the same writable word returns the
    // incoming masked value, because the register itself only changes on this edge.
    if ((state == AANCR_ST_WRITE) && (wr_idx == rd_idx) && (wr_mask != 8'h00))
      next_rdata = {24'h00_0000, i_hwdata[7:0] & wr_mask};
  end

  // Read data is registered so it stands in the data phase.
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_nrst)
    begin
      o_hrdata <= '0;
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
    end
    else
    begin
      // Zero wait states; response is always OKAY.
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
      if (addr_ok && !i_hwrite)
        o_hrdata <= next_rdata;
    end
  end

  // Result and divisor outputs, registered.
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_nrst)
    begin
      o_result <= '0;
      o_rate_divisor <= `AANCR_DIV_125;
    end
    else
    begin
      o_result <= next_result;
      o_rate_divisor <= next_divisor;
    end
  end

  // Analog controls are decoded from the incoming write data on the same edge
  // the registers take a write, so both change together.
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_nrst)
    begin
      o_ctrl <= '0;
    end
    else if (state == AANCR_ST_WRITE)
    begin
      // Mirror the incoming masked write for the target register.
      o_ctrl <= o_ctrl;
      if (wr_idx == `AANCR_IDX_FRATE)
      begin
        o_ctrl.comb_filter_enable <= i_hwdata[`AANCR_COMB_BIT];
        o_ctrl.output_rate_select <= i_hwdata[2:0];
      end
      else if (wr_idx == `AANCR_IDX_CHOP)
      begin
        o_ctrl.chopper_mode_select <= i_hwdata[3:2];
        o_ctrl.chop_enable <= i_hwdata[3];
        o_ctrl.chop_polarity_neg <= !i_hwdata[3] && i_hwdata[2];
      end
      else if (wr_idx == `AANCR_IDX_INSEL)
      begin
        o_ctrl.negative_input_select <= i_hwdata[7:6];
        o_ctrl.filter_input_select <= i_hwdata[5:3];
        o_ctrl.filter_enable <= i_hwdata[`AANCR_FEN_BIT];
        o_ctrl.positive_input_select <= i_hwdata[1:0];
      end
      else if (wr_idx == `AANCR_IDX_REFSEL)
      begin
        o_ctrl.amp_inverting_select <= i_hwdata[5:4];
        o_ctrl.negative_reference_select <= i_hwdata[3:2];
        o_ctrl.positive_reference_select <= i_hwdata[1:0];
      end
      else if (wr_idx == `AANCR_IDX_GAIN)
      begin
        o_ctrl.internal_reference_enable <= i_hwdata[`AANCR_REFEN_BIT];
        o_ctrl.input_gain_select <= i_hwdata[3:2];
        o_ctrl.converter_enable <= i_hwdata[`AANCR_CEN_BIT];
        o_ctrl.auto_zero_short <= i_hwdata[`AANCR_AZ_BIT];
      end
      else if (wr_idx == `AANCR_IDX_AMP)
      begin
        o_ctrl.amplifier_enable <= i_hwdata[`AANCR_AEN_BIT];
        o_ctrl.amp_noninverting_select <= i_hwdata[2:0];
      end
    end
  end

  // Assertions.
  property p_zero_result;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      !frate_reg[`AANCR_COMB_BIT] |=> (o_result == 24'h00_0000);
  endproperty
  a_zero_result: assert property (p_zero_result) else $error("Result not zero with filter off.");

  property p_rate_top;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      (frate_reg[2:0] == 3'h7) |=> (o_rate_divisor == 16'h1f40);
  endproperty
  a_rate_top: assert property (p_rate_top) else $error("Rate code 111 not 8000.");

  property p_rate_base;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      (frate_reg[2:0] == 3'h0) |=> (o_rate_divisor == 16'h007d);
  endproperty
  a_rate_base: assert property (p_rate_base) else $error("Rate code 000 not 125.");

  property p_chop_mask;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      (chop_reg & 8'hf3) == 8'h00;
  endproperty
  a_chop_mask: assert property (p_chop_mask) else $error("Chopper register reserved bit set.");

  property p_chop_on;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      (o_ctrl.chop_enable == chop_reg[`AANCR_CHOP_LSB + 1]) &&
        (o_ctrl.chopper_mode_select == chop_reg[`AANCR_CHOP_LSB +: 2]);
  endproperty
  a_chop_on: assert property (p_chop_on) else $error("Chop enable disagrees with mode.");

  property p_chop_pol;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      o_ctrl.chop_polarity_neg == (chop_reg[`AANCR_CHOP_LSB +: 2] == AANCR_CHOP_NEG_OFS);
  endproperty
  a_chop_pol: assert property (p_chop_pol) else $error("Chop polarity wrong.");

  property p_ctrl_track;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      ##1 (o_ctrl.input_gain_select == gain_reg[3:2]) && (o_ctrl.converter_enable == gain_reg[1]);
  endproperty
  a_ctrl_track: assert property (p_ctrl_track) else $error("Gain controls differ from register.");

  property p_sel_track;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      ##1 (o_ctrl.negative_input_select == insel_reg[7:6]) && (o_ctrl.filter_enable == insel_reg[2]);
  endproperty
  a_sel_track: assert property (p_sel_track) else $error("Input selects differ from register.");

  property p_amp_track;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      ##1 (o_ctrl.amplifier_enable == amp_reg[3]) && (o_ctrl.amp_noninverting_select == amp_reg[2:0]);
  endproperty
  a_amp_track: assert property (p_amp_track) else $error("Amplifier controls differ from register.");

  property p_rd_fwd;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      (addr_ok && !i_hwrite && (state == AANCR_ST_WRITE) && (wr_idx == rd_idx) && (wr_idx == `AANCR_IDX_AMP))
        |=> (o_hrdata == {24'h00_0000, $past(i_hwdata[7:0]) & `AANCR_MASK_AMP});
  endproperty
  a_rd_fwd: assert property (p_rd_fwd) else $error("Read after write returned stale data.");

  property p_write_land;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      ((state == AANCR_ST_WRITE) && (wr_idx == `AANCR_IDX_GAIN))
        |=> (gain_reg == ($past(i_hwdata[7:0]) & `AANCR_MASK_GAIN));
  endproperty
  a_write_land: assert property (p_write_land) else $error("Gain register write did not land.");

  property p_result_pass;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      frate_reg[`AANCR_COMB_BIT] |=> (o_result == $past(i_conv_result));
  endproperty
  a_result_pass: assert property (p_result_pass) else $error("Result not passed with filter on.");

  property p_fin_track;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      (o_ctrl.filter_input_select == insel_reg[`AANCR_FIN_LSB +: 3]) &&
        (o_ctrl.positive_input_select == insel_reg[`AANCR_POS_LSB +: 2]);
  endproperty
  a_fin_track: assert property (p_fin_track) else $error("Filter input selects differ from register.");

  property p_ref_track;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      (o_ctrl.negative_reference_select == refsel_reg[`AANCR_VRL_LSB +: 2]) &&
        (o_ctrl.positive_reference_select == refsel_reg[`AANCR_VRH_LSB +: 2]) &&
        (o_ctrl.amp_inverting_select == refsel_reg[`AANCR_AINV_LSB +: 2]);
  endproperty
  a_ref_track: assert property (p_ref_track) else $error("Reference selects differ from register.");

  property p_refen_track;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      (o_ctrl.internal_reference_enable == gain_reg[`AANCR_REFEN_BIT]) &&
        (o_ctrl.auto_zero_short == gain_reg[`AANCR_AZ_BIT]);
  endproperty
  a_refen_track: assert property (p_refen_track) else $error("Reference or short differs from register.");

  property p_rate_track;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      (o_ctrl.comb_filter_enable == frate_reg[`AANCR_COMB_BIT]) &&
        (o_ctrl.output_rate_select == frate_reg[`AANCR_RATE_LSB +: 3]);
  endproperty
  a_rate_track: assert property (p_rate_track) else $error("Rate controls differ from register.");

endmodule

/* tb/aancr_analog_model.sv */
/*
  Behavioural model of the converter that sits behind the register bank.
  Assumes it shares the bank's clock and reads the bank's analog controls.
*/
`timescale 1ns/1ps
module aancr_analog_model
  import aancr_pkg::*;
#(
  parameter logic [23:0] RESULT = 24'h12_3456 // Steady conversion value.
)
(
  input wire logic i_sys_clk, // System clock.
  input wire aancr_ctrl_t i_ctrl, // Analog controls from the bank.
  output logic [23:0] o_conv_result // Raw result toward the bank.
);
  // A stopped converter holds no steady value, so its output keeps changing.
  always @(posedge i_sys_clk)
  begin
    if (i_ctrl.converter_enable !== 1'b1)
      o_conv_result <= (o_conv_result === 24'h5a_5a5a) ? 24'ha5_a5a5 : 24'h5a_5a5a;
    else if (i_ctrl.auto_zero_short)
      o_conv_result <= 24'h00_0000;
    else
      o_conv_result <= RESULT;
  end
endmodule

/* tb/testbench.sv */
/*
  Self-checking bench of the analog network register bank.
  Assumes the package, the design and the analog model are compiled first.
*/
`timescale 1ns/1ps
module testbench;
  import aancr_pkg::*;
  localparam logic [23:0] CONV_VAL = 24'h12_3456; // Model's steady result.
  logic i_sys_clk = 1'b0; // System clock.
  logic i_nrst = 1'b0; // Reset, active low.
  logic hsel = 1'b0; // Bus select.
  logic [31:0] haddr = 32'h0000_0000; // Bus address.
  logic [1:0] htrans = 2'h0; // Transfer type.
  logic hwrite = 1'b0; // Write strobe.
  logic [31:0] hwdata = 32'h0000_0000; // Write data.
  wire hready; // Slave ready fed back as bus ready.
  logic [31:0] hrdata; // Read data.
  logic hresp; // Response.
  logic [23:0] conv; // Raw result from the model.
  logic [23:0] result; // Result seen by software.
  logic [15:0] divisor; // Rate divisor.
  aancr_ctrl_t ctrl; // Analog controls.
  logic [31:0] rd; // Last read data.
  int n_mismatch = 0;
  int n_compared = 0;
  // Rows: register index, byte written, byte expected back.
  logic [23:0] rows [14] = '{24'h13_ff0f, 24'h15_ff0c, 24'h18_ffff, 24'h19_ff3f, 24'h1a_ff8f,
    24'h1b_ff0f, 24'h30_ff00, 24'h12_ff00, 24'h13_0b0b, 24'h15_0808, 24'h18_d6d6,
    24'h19_2d2d, 24'h1a_8b8b, 24'h1b_0d0d};

  aancr_regs u_dut (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready),
    .i_conv_result(conv), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
    .o_ctrl(ctrl), .o_result(result), .o_rate_divisor(divisor));

  aancr_analog_model #(.RESULT(CONV_VAL)) u_model (.i_sys_clk(i_sys_clk), .i_ctrl(ctrl),
    .o_conv_result(conv));

  // The clock toggles every half period of 5 ns.
  always #5 i_sys_clk = ~i_sys_clk;

  // Prints the counts and the verdict, then ends the run.
  task conclude;
    $display("compared=%0d mismatches=%0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Compares a seen value with the expected one.
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Waits for a rising edge with ready high, under a bound.
  task wait_rdy;
    int n;
    n = 0;
    @(posedge i_sys_clk);
    while (hready !== 1'b1 && n < 50)
    begin
      @(posedge i_sys_clk);
      n++;
    end
    if (n >= 50)
    begin
      n_mismatch++;
      conclude();
    end
  endtask

  // One single word transfer: address phase, then data phase.
  task bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    hsel <= 1'b1;
    haddr <= {22'h00_0000, idx, 2'b00};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h00_0000, wd};
    wait_rdy();
    rd = hrdata;
  endtask

  // Write then read of one word back to back: the read address phase
  // overlaps the write data phase.
  task bus_wr_rd(input logic [7:0] idx, input logic [7:0] wd);
    hsel <= 1'b1;
    haddr <= {22'h00_0000, idx, 2'b00};
    htrans <= 2'h2;
    hwrite <= 1'b1;
    wait_rdy();
    hwrite <= 1'b0;
    hwdata <= {24'h00_0000, wd};
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    wait_rdy();
    rd = hrdata;
  endtask

  // Reads a register and compares the byte.
  task rchk(input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    chk(rd, {24'h00_0000, exp});
  endtask

  // A hang is cut short here.
  initial
  begin
    #200_000;
    n_mismatch++;
    conclude();
  end

  // Main sequence: reset, table of register rows, then hand-written cases.
  initial
  begin
    repeat (20) @(posedge i_sys_clk);
    i_nrst <= 1'b1;
    #1;
    chk({1'b0, ctrl}, 32'h0000_0000);
    chk({16'h0000, divisor}, 32'h0000_007d);
    chk({30'h0000_0000, hready, hresp}, 32'h0000_0002);
    foreach (rows[i])
      rchk(rows[i][23:16], 8'h00);
    foreach (rows[i])
    begin
      bus(1'b1, rows[i][23:16], rows[i][15:8]);
      rchk(rows[i][23:16], rows[i][7:0]);
      if (i == 7)
        chk({1'b0, ctrl}, 32'h7f7f_ffff);
    end
    // Each field as left by the last row for its register, in the package's field order.
    chk({1'b0, ctrl}, 32'h5d6b_5bbd);
    for (int c = 0; c < 4; c++)
    begin
      bus(1'b1, 8'h15, {4'h0, c[1:0], 2'b00});
      #1;
      chk({28'h0, ctrl.chopper_mode_select, ctrl.chop_enable, ctrl.chop_polarity_neg},
        {28'h0, c[1:0], c[1], c == 1});
    end
    for (int c = 0; c < 8; c++)
    begin
      bus(1'b1, 8'h13, {4'h0, 1'b1, c[2:0]});
      // The divisor is registered one edge after the write lands.
      @(posedge i_sys_clk);
      #1;
      chk({16'h0000, divisor}, (c == 7) ? 32'h0000_1f40 : (32'h0000_007d << c));
    end
    bus(1'b1, 8'h1a, 8'h02);
    repeat (4) @(posedge i_sys_clk);
    #1;
    chk({8'h00, result}, {8'h00, CONV_VAL});
    rchk(8'h12, CONV_VAL[7:0]);
    bus(1'b1, 8'h13, 8'h00);
    repeat (4) @(posedge i_sys_clk);
    #1;
    chk({8'h00, result}, 32'h0000_0000);
    rchk(8'h12, 8'h00);
    bus(1'b1, 8'h13, 8'h08);
    bus(1'b1, 8'h1a, 8'h03);
    repeat (4) @(posedge i_sys_clk);
    #1;
    chk({8'h00, result}, 32'h0000_0000);
    bus_wr_rd(8'h1b, 8'hff);
    chk(rd, 32'h0000_000f);
    @(posedge i_sys_clk);
    i_nrst <= 1'b0;
    @(posedge i_sys_clk);
    i_nrst <= 1'b1;
    #1;
    chk({1'b0, ctrl}, 32'h0000_0000);
    chk({16'h0000, divisor}, 32'h0000_007d);
    conclude();
  end
endmodule
